// [cpl_err_pkg.sv]
// Package: register map, field positions and carrier types for the completion error block
package cpl_err_pkg;

  localparam int addr_width = 4;
  // Word indices on the Avalon-MM slave
  localparam logic [3:0] reg_command_status = 4'h0;
  localparam logic [3:0] reg_secondary_status = 4'h1;
  localparam logic [3:0] reg_hdr_log0 = 4'h2;
  localparam logic [3:0] reg_hdr_log1 = 4'h3;
  localparam logic [3:0] reg_hdr_log2 = 4'h4;
  localparam logic [3:0] reg_hdr_log3 = 4'h5;
  localparam logic [3:0] reg_irq_status = 4'h6;
  localparam logic [3:0] reg_irq_enable = 4'h7;
  localparam logic [3:0] reg_irq_clear = 4'h8;
  localparam logic [3:0] reg_control = 4'h9;
  localparam logic [3:0] reg_burst_err = 4'hA;

  // Abort flag positions inside both status registers (write one to clear)
  localparam int bit_target_abort = 28;
  localparam int bit_master_abort = 29;
  // Completion status field in header word 1
  localparam int cpl_status_lo = 21;
  localparam int cpl_status_hi = 23;
  localparam logic [2:0] cpl_status_ok = 3'h0;
  localparam logic [2:0] cpl_status_ur = 3'h1;
  localparam logic [2:0] cpl_status_ca = 3'h4;

  // Interrupt status / enable / clear bit positions
  localparam int irq_ur = 0;
  localparam int irq_ca = 1;
  localparam int irq_burst = 2;
  localparam int irq_count = 3;

  // Control register bit: root complex mode
  localparam int ctl_rc_mode = 0;
  localparam logic [31:0] ctl_reset = 32'h0000_0001;

  localparam int burst_align_bytes = 16;
  localparam logic [31:0] unmapped_read = 32'h0000_0000;

  typedef struct packed {
    logic [31:0] dw0;
    logic [31:0] dw1;
    logic [31:0] dw2;
    logic [31:0] dw3;
  } cpl_header_type;

  typedef struct packed {
    logic valid;
    cpl_header_type header;
  } cpl_in_type;

  typedef struct packed {
    logic valid;
    logic [31:0] byte_addr;
    logic [15:0] byte_count;
  } burst_in_type;

endpackage

// [cpl_err_status.sv]
// Completion error status, header log and slave-port burst checker behind an Avalon-MM slave
//
// Our own choices: the Avalon-MM register port and the placing of the registers.
module cpl_err_status (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [cpl_err_pkg::addr_width-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire cpl_err_pkg::cpl_in_type cpl_in,
  input wire cpl_err_pkg::burst_in_type burst_in,
  output logic irq
);

  localparam logic [31:0] abort_mask = (32'h0000_0001 << cpl_err_pkg::bit_target_abort) |
                                       (32'h0000_0001 << cpl_err_pkg::bit_master_abort);
  localparam logic [3:0] align_mask = 4'(cpl_err_pkg::burst_align_bytes - 1);

  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  logic [31:0] command_status;
  logic [31:0] secondary_status_reg;
  cpl_err_pkg::cpl_header_type hdr_log;
  logic [cpl_err_pkg::irq_count-1:0] irq_status;
  logic [cpl_err_pkg::irq_count-1:0] irq_enable;
  logic [31:0] control;
  logic [31:0] burst_err_addr;
  logic ack;

  // Single-cycle wait state: the request is answered on the second edge it is held
  wire req = (avs_read | avs_write) & ~ack;
  wire wr_take = avs_write & ack;
  wire [31:0] wmask = be_mask(avs_byteenable);
  wire sel_cs = wr_take & (avs_address == cpl_err_pkg::reg_command_status);
  wire sel_ss = wr_take & (avs_address == cpl_err_pkg::reg_secondary_status);
  wire sel_en = wr_take & (avs_address == cpl_err_pkg::reg_irq_enable);
  wire sel_clr = wr_take & (avs_address == cpl_err_pkg::reg_irq_clear);
  wire sel_ctl = wr_take & (avs_address == cpl_err_pkg::reg_control);

  wire rc_mode = control[cpl_err_pkg::ctl_rc_mode];
  wire [2:0] in_status = cpl_in.header.dw1[cpl_err_pkg::cpl_status_hi:cpl_err_pkg::cpl_status_lo];
  wire cpl_ur = cpl_in.valid & rc_mode & (in_status == cpl_err_pkg::cpl_status_ur);
  wire cpl_ca = cpl_in.valid & rc_mode & (in_status == cpl_err_pkg::cpl_status_ca);
  wire cpl_bad = cpl_in.valid & rc_mode & (in_status != cpl_err_pkg::cpl_status_ok);

  // Misuse by the master cannot be prevented here, only flagged for software
  wire burst_bad = burst_in.valid & (burst_in.byte_count > 16'h0004) &
                   (((burst_in.byte_addr[3:0] & align_mask) != 4'h0) |
                    ((burst_in.byte_count[3:0] & align_mask) != 4'h0));

  wire [31:0] abort_set = ({31'h0000_0000, cpl_ur} << cpl_err_pkg::bit_master_abort) |
                          ({31'h0000_0000, cpl_ca} << cpl_err_pkg::bit_target_abort);
  // Set wins over a same-cycle clear
  wire [31:0] next_command_status = (command_status & ~(sel_cs ? (avs_writedata & wmask & abort_mask) : 32'h0000_0000))
                                    | abort_set;
  wire [31:0] next_secondary_status = (secondary_status_reg &
                                       ~(sel_ss ? (avs_writedata & wmask & abort_mask) : 32'h0000_0000))
                                      | abort_set;
  wire [cpl_err_pkg::irq_count-1:0] irq_events = {burst_bad, cpl_ca, cpl_ur};
  wire [cpl_err_pkg::irq_count-1:0] next_irq_status =
    (irq_status & ~(sel_clr ? avs_writedata[cpl_err_pkg::irq_count-1:0] : 3'h0)) | irq_events;

  wire [31:0] rd_mux =
    (avs_address == cpl_err_pkg::reg_command_status) ? command_status :
    (avs_address == cpl_err_pkg::reg_secondary_status) ? secondary_status_reg :
    (avs_address == cpl_err_pkg::reg_hdr_log0) ? hdr_log.dw0 :
    (avs_address == cpl_err_pkg::reg_hdr_log1) ? hdr_log.dw1 :
    (avs_address == cpl_err_pkg::reg_hdr_log2) ? hdr_log.dw2 :
    (avs_address == cpl_err_pkg::reg_hdr_log3) ? hdr_log.dw3 :
    (avs_address == cpl_err_pkg::reg_irq_status) ? {29'h0000_0000, irq_status} :
    (avs_address == cpl_err_pkg::reg_irq_enable) ? {29'h0000_0000, irq_enable} :
    (avs_address == cpl_err_pkg::reg_control) ? control :
    (avs_address == cpl_err_pkg::reg_burst_err) ? burst_err_addr :
    cpl_err_pkg::unmapped_read;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ack <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else if (clk_en) begin
      ack <= req;
      avs_waitrequest <= ~req;
      avs_readdata <= (req & avs_read) ? rd_mux : avs_readdata;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      command_status <= 32'h0000_0000;
      secondary_status_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      command_status <= next_command_status;
      secondary_status_reg <= next_secondary_status;
    end
  end

  // Log is overwritten by each new erroneous completion in root complex mode; software reads it after the flag
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hdr_log <= '0;
    end else if (clk_en && cpl_bad) begin
      hdr_log <= cpl_in.header;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_status <= 3'h0;
      irq_enable <= 3'h0;
      control <= cpl_err_pkg::ctl_reset;
      burst_err_addr <= 32'h0000_0000;
      irq <= 1'b0;
    end else if (clk_en) begin
      irq_status <= next_irq_status;
      irq_enable <= sel_en ? avs_writedata[cpl_err_pkg::irq_count-1:0] : irq_enable;
      control <= sel_ctl ? ((control & ~wmask) | (avs_writedata & wmask)) : control;
      burst_err_addr <= burst_bad ? burst_in.byte_addr : burst_err_addr;
      irq <= |(next_irq_status & (sel_en ? avs_writedata[cpl_err_pkg::irq_count-1:0] : irq_enable));
    end
  end

  sequence s_ur_seen;
    clk_en && cpl_ur;
  endsequence

  sequence s_ca_seen;
    clk_en && cpl_ca;
  endsequence

  a_ur_sets_master: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_ur_seen |=> command_status[cpl_err_pkg::bit_master_abort] && secondary_status_reg[cpl_err_pkg::bit_master_abort])
    else $error("Master abort flag not set after unsupported request completion");

  a_ca_sets_target: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_ca_seen |=> command_status[cpl_err_pkg::bit_target_abort] && secondary_status_reg[cpl_err_pkg::bit_target_abort])
    else $error("Target abort flag not set after completer abort completion");

  a_rc_only_report: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && !command_status[cpl_err_pkg::bit_master_abort] && !cpl_ur && !sel_cs
    |=> !command_status[cpl_err_pkg::bit_master_abort])
    else $error("Master abort flag rose without an unsupported request completion");

  a_header_logged: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && cpl_bad |=> hdr_log == $past(cpl_in.header))
    else $error("Erroneous completion header not logged");

  a_status_field: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_ur_seen |=> hdr_log.dw1[cpl_err_pkg::cpl_status_hi:cpl_err_pkg::cpl_status_lo] == 3'h1)
    else $error("Logged completion status is not unsupported request");

  a_flag_sticky: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && secondary_status_reg[cpl_err_pkg::bit_target_abort] && !sel_ss
    |=> secondary_status_reg[cpl_err_pkg::bit_target_abort])
    else $error("Target abort flag cleared without software write");

  a_irq_level: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en ##1 1'b1 |-> irq == |(irq_status & irq_enable))
    else $error("Interrupt output does not follow enabled status");

  a_bus_answer: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && req ##1 clk_en |-> !avs_waitrequest)
    else $error("Bus request not answered after one wait state");

  a_burst_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && burst_bad |=> irq_status[cpl_err_pkg::irq_burst] && burst_err_addr == $past(burst_in.byte_addr))
    else $error("Misaligned burst not flagged");

  // Handshake and completion steps shared by the checks below
  sequence s_bus_take;
    clk_en && req;
  endsequence

  sequence s_bus_idle;
    clk_en && !req;
  endsequence

  sequence s_good_cpl;
    clk_en && cpl_in.valid && (in_status == cpl_err_pkg::cpl_status_ok);
  endsequence

  sequence s_quiet_cycle;
    clk_en && !cpl_bad;
  endsequence

  a_ca_status_field: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_ca_seen |=> hdr_log.dw1[cpl_err_pkg::cpl_status_hi:cpl_err_pkg::cpl_status_lo]
                  == cpl_err_pkg::cpl_status_ca)
    else $error("Logged completion status is not completer abort");

  a_ur_sets_irq: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_ur_seen |=> irq_status[cpl_err_pkg::irq_ur])
    else $error("Unsupported request completion did not raise its interrupt status");

  a_ca_sets_irq: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_ca_seen |=> irq_status[cpl_err_pkg::irq_ca])
    else $error("Completer abort completion did not raise its interrupt status");

  // Abort flags move only on their own completion or on a software clear
  a_master_sticky: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && command_status[cpl_err_pkg::bit_master_abort] && !sel_cs
    |=> command_status[cpl_err_pkg::bit_master_abort])
    else $error("Master abort flag cleared without software write");

  a_target_sticky: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && command_status[cpl_err_pkg::bit_target_abort] && !sel_cs
    |=> command_status[cpl_err_pkg::bit_target_abort])
    else $error("Target abort flag in command status cleared without software write");

  a_sec_master_sticky: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && secondary_status_reg[cpl_err_pkg::bit_master_abort] && !sel_ss
    |=> secondary_status_reg[cpl_err_pkg::bit_master_abort])
    else $error("Secondary master abort flag cleared without software write");

  a_no_target_rise: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && !command_status[cpl_err_pkg::bit_target_abort] && !cpl_ca
    |=> !command_status[cpl_err_pkg::bit_target_abort])
    else $error("Target abort flag rose without a completer abort completion");

  a_sec_master_rise: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && !secondary_status_reg[cpl_err_pkg::bit_master_abort] && !cpl_ur
    |=> !secondary_status_reg[cpl_err_pkg::bit_master_abort])
    else $error("Secondary master abort flag rose without an unsupported request completion");

  a_sec_target_rise: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && !secondary_status_reg[cpl_err_pkg::bit_target_abort] && !cpl_ca
    |=> !secondary_status_reg[cpl_err_pkg::bit_target_abort])
    else $error("Secondary target abort flag rose without a completer abort completion");

  a_ur_no_target: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_ur_seen ##0 !command_status[cpl_err_pkg::bit_target_abort] |=> !command_status[cpl_err_pkg::bit_target_abort])
    else $error("Unsupported request completion set the target abort flag");

  a_ca_no_master: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_ca_seen ##0 !command_status[cpl_err_pkg::bit_master_abort] |=> !command_status[cpl_err_pkg::bit_master_abort])
    else $error("Completer abort completion set the master abort flag");

  a_rc_gate_cs: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && !rc_mode && !sel_cs |=> $stable(command_status))
    else $error("Command status changed outside root complex mode");

  a_rc_gate_ss: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && !rc_mode && !sel_ss |=> $stable(secondary_status_reg))
    else $error("Secondary status changed outside root complex mode");

  a_log_holds: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_quiet_cycle |=> $stable(hdr_log))
    else $error("Header log changed without an erroneous completion");

  a_good_keeps_flags: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_good_cpl ##0 !sel_cs
    |=> (command_status & $past(command_status)) == $past(command_status))
    else $error("Successful completion cleared an abort flag");

  // A low enable must hold every register, or a stalled bus would lose events
  a_frozen_state: assert property (@(posedge ref_clk) disable iff (!resetn)
    !clk_en |=> $stable(command_status) && $stable(secondary_status_reg)
                && $stable(irq_status) && $stable(hdr_log))
    else $error("State changed while clock enable was low");

  a_frozen_bus: assert property (@(posedge ref_clk) disable iff (!resetn)
    !clk_en |=> $stable(avs_waitrequest) && $stable(avs_readdata) && $stable(irq))
    else $error("Outputs changed while clock enable was low");

  a_wait_single: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && !avs_waitrequest |=> avs_waitrequest)
    else $error("Waitrequest stayed low for more than one cycle");

  a_no_spurious_answer: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_bus_idle |=> avs_waitrequest)
    else $error("Bus answered without a request");

  a_control_readback: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_bus_take ##0 (avs_read && avs_address == cpl_err_pkg::reg_control)
    |=> avs_readdata == $past(control))
    else $error("Control register read back wrong");

  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
    (command_status & ~abort_mask) == 32'h0000_0000
    && (secondary_status_reg & ~abort_mask) == 32'h0000_0000)
    else $error("Status register bit outside the abort flags is set");

  a_master_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && sel_cs && avs_writedata[cpl_err_pkg::bit_master_abort] && avs_byteenable[3] && !cpl_ur
    |=> !command_status[cpl_err_pkg::bit_master_abort])
    else $error("Software write did not clear the master abort flag");

  a_irq_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && sel_clr && avs_writedata[cpl_err_pkg::irq_ur] && !cpl_ur
    |=> !irq_status[cpl_err_pkg::irq_ur])
    else $error("Interrupt clear write did not clear the status bit");

  a_clean_burst: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && burst_in.valid && burst_in.byte_addr[3:0] == 4'h0 && burst_in.byte_count[3:0] == 4'h0
    |=> $stable(burst_err_addr))
    else $error("Aligned whole-line burst was flagged");

  a_irq_disabled_low: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && irq_enable == 3'h0 && !sel_en |=> !irq)
    else $error("Interrupt raised with every source disabled");

endmodule // cpl_err_status

// [link_partner.sv]
// Far-side model: completer returning completions and a DMA master issuing slave-port bursts
module link_partner (
  input wire logic ref_clk,
  output cpl_err_pkg::cpl_in_type cpl_in,
  output cpl_err_pkg::burst_in_type burst_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cpl_in = '0;
    burst_in = '0;
  end
  // One-cycle completion; payload inverted afterwards so a stale header is never mistaken for a live one
  task automatic complete(input logic [2:0] status, input logic [31:0] tag);
    cpl_err_pkg::cpl_header_type h;
    h = {tag, tag & 32'hff1f_ffff, ~tag, tag ^ 32'h5555_5555};
    h.dw1[23:21] = status;
    @(posedge ref_clk);
    cpl_in <= {1'b1, h};
    @(posedge ref_clk);
    cpl_in <= {1'b0, ~h};
  endtask
  // Callers pass whole aligned 16-byte lines except for a short 4-byte burst and where a bad burst is wanted
  task automatic burst(input logic [31:0] addr, input logic [15:0] count);
    @(posedge ref_clk);
    burst_in <= {1'b1, addr, count};
    @(posedge ref_clk);
    burst_in <= {1'b0, ~addr, ~count};
  endtask
endmodule // link_partner

// [tb.sv]
// Self-checking bench for the completion error status block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic clk_en = 1'b1;
  logic [3:0] avs_byteenable = 4'hf;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic [31:0] q;
  logic avs_waitrequest;
  logic irq;
  cpl_err_pkg::cpl_in_type cpl_in;
  cpl_err_pkg::burst_in_type burst_in;
  int err_count = 0;
  int n_compared = 0;
  always #5 ref_clk = ~ref_clk;
  cpl_err_status cpl_err_status_inst (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cpl_in(cpl_in), .burst_in(burst_in), .irq(irq));
  link_partner link_partner_inst (.ref_clk(ref_clk), .cpl_in(cpl_in), .burst_in(burst_in));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d, compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Holds the request until waitrequest is seen low; only the watchdog ends a hung wait
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(q, exp);
  endtask
  task automatic test_reset;
    check({31'h0, irq}, 32'h0000_0000);
    rd(cpl_err_pkg::reg_control, cpl_err_pkg::ctl_reset);
    rd(cpl_err_pkg::reg_command_status, 32'h0000_0000);
    rd(cpl_err_pkg::reg_irq_status, 32'h0000_0000);
    rd(4'hB, cpl_err_pkg::unmapped_read);
  endtask
  task automatic test_abort(input logic [2:0] st, input int fb, input int ib, input logic [31:0] tag);
    logic [31:0] w1;
    logic [31:0] f;
    logic [31:0] e;
    w1 = (tag & 32'hff1f_ffff) | (32'(st) << 21);
    f = 32'h0000_0001 << fb;
    e = 32'h0000_0001 << ib;
    link_partner_inst.complete(st, tag);
    rd(cpl_err_pkg::reg_command_status, f);
    rd(cpl_err_pkg::reg_secondary_status, f);
    rd(cpl_err_pkg::reg_hdr_log0, tag);
    rd(cpl_err_pkg::reg_hdr_log1, w1);
    check({31'h0, irq}, 32'h0000_0000);
    bus(1'b1, cpl_err_pkg::reg_irq_enable, e);
    rd(cpl_err_pkg::reg_irq_status, e);
    check({31'h0, irq}, 32'h0000_0001);
    link_partner_inst.complete(cpl_err_pkg::cpl_status_ok, ~tag);
    rd(cpl_err_pkg::reg_command_status, f);
    rd(cpl_err_pkg::reg_hdr_log1, w1);
    avs_byteenable <= 4'h7;
    bus(1'b1, cpl_err_pkg::reg_command_status, f);
    avs_byteenable <= 4'hf;
    rd(cpl_err_pkg::reg_command_status, f);
    bus(1'b1, cpl_err_pkg::reg_command_status, f);
    bus(1'b1, cpl_err_pkg::reg_secondary_status, f);
    bus(1'b1, cpl_err_pkg::reg_irq_clear, e);
    rd(cpl_err_pkg::reg_secondary_status, 32'h0000_0000);
    rd(cpl_err_pkg::reg_irq_status, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
    bus(1'b1, cpl_err_pkg::reg_irq_enable, 32'h0000_0000);
  endtask
  // A frozen clock enable drops the completion; without root complex mode no completion is reported
  task automatic test_gating;
    @(posedge ref_clk);
    clk_en <= 1'b0;
    link_partner_inst.complete(cpl_err_pkg::cpl_status_ur, 32'h0f0f_0f0f);
    clk_en <= 1'b1;
    rd(cpl_err_pkg::reg_command_status, 32'h0000_0000);
    bus(1'b1, cpl_err_pkg::reg_control, 32'h0000_0000);
    link_partner_inst.complete(cpl_err_pkg::cpl_status_ca, 32'h3c3c_3c3c);
    rd(cpl_err_pkg::reg_secondary_status, 32'h0000_0000);
    rd(cpl_err_pkg::reg_hdr_log0, 32'h9abc_def0);
    bus(1'b1, cpl_err_pkg::reg_control, cpl_err_pkg::ctl_reset);
  endtask
  task automatic test_burst;
    bus(1'b1, cpl_err_pkg::reg_irq_enable, 32'h0000_0004);
    link_partner_inst.burst(32'h0000_0100, 16'h0020);
    link_partner_inst.burst(32'h0000_0102, 16'h0004);
    rd(cpl_err_pkg::reg_irq_status, 32'h0000_0000);
    link_partner_inst.burst(32'h0000_0104, 16'h0020);
    rd(cpl_err_pkg::reg_burst_err, 32'h0000_0104);
    check({31'h0, irq}, 32'h0000_0001);
    bus(1'b1, cpl_err_pkg::reg_irq_clear, 32'h0000_0004);
    link_partner_inst.burst(32'h0000_0200, 16'h0014);
    rd(cpl_err_pkg::reg_irq_status, 32'h0000_0004);
    rd(cpl_err_pkg::reg_burst_err, 32'h0000_0200);
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    test_reset;
    test_abort(cpl_err_pkg::cpl_status_ur, cpl_err_pkg::bit_master_abort, cpl_err_pkg::irq_ur, 32'h1234_5678);
    test_abort(cpl_err_pkg::cpl_status_ca, cpl_err_pkg::bit_target_abort, cpl_err_pkg::irq_ca, 32'h9abc_def0);
    test_gating;
    test_burst;
    stop_test;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    stop_test;
  end
endmodule // tb
